// [adccfg_map.svh]
// register offsets, field positions, defaults and frame bit counts
// assumes a 20 MHz system clock sampling the serial pins
`ifndef ADCCFG_MAP_SVH
`define ADCCFG_MAP_SVH
`define ADCCFG_OFS_PORT_CFG 8'h00
`define ADCCFG_OFS_PART_ID 8'h01
`define ADCCFG_OFS_GRADE 8'h02
`define ADCCFG_OFS_SEL_UPPER 8'h04
`define ADCCFG_OFS_SEL_LOWER 8'h05
`define ADCCFG_OFS_TRANSFER 8'hFF
`define ADCCFG_RST_PORT_CFG 8'h18
`define ADCCFG_RST_GRADE 8'h00
`define ADCCFG_RST_SEL_UPPER 8'h0F
`define ADCCFG_RST_SEL_LOWER 8'h0F
`define ADCCFG_PART_ID_DEF 8'h5A
`define ADCCFG_BIT_LSB_HI 6
`define ADCCFG_BIT_LSB_LO 1
`define ADCCFG_BIT_SRST_HI 5
`define ADCCFG_BIT_SRST_LO 2
`define ADCCFG_GRADE_LSB 4
`define ADCCFG_XFER_GO 8'h01
`define ADCCFG_INSTR_BITS 16
`define ADCCFG_BYTE_BITS 8
`endif

// [adccfg_pkg.sv]
// types for the configuration register bank
// assumes adccfg_map.svh constants
package adccfg_pkg;
   typedef enum logic [1:0] {
      ADCCFG_IDLE,
      ADCCFG_INSTR,
      ADCCFG_DATA
   } adccfg_state_t;
   typedef logic [7:0] adccfg_byte_t;
endpackage

// [adccfg_regs.sv]
// configuration and channel-select registers behind a three-wire serial port
// assumes serial pins synchronous to clk and sclk far slower than clk
//
// Notes on behaviour
// - any reset loads every defined default
// - bit 6 or 1 selects lsb-first shifting
// - bit 5 or 2 requests soft reset
// - mirrored nibbles, fixed bits, default 0x18
// - part identifier read only, fixed value
// - grade field in bits 6 to 4
// - channel bits mask channel-specific writes
// - lower select bits 3:0 channels A-D
// - upper select bits 3:0 channels E-H
// - lower bits 5,4 select clock outputs
// - select writes apply after transfer write 0x01
`timescale 1ns/1ps
`include "adccfg_map.svh"
module adccfg_regs #(
   parameter logic [7:0] PART_ID = `ADCCFG_PART_ID_DEF, // arbitrary value
   parameter logic [2:0] SPEED_GRADE = 3'h0
)(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic sclk,
   input wire logic serial_select_n,
   input wire logic sdio_i,
   output logic sdio_o,
   output logic sdio_oe_n,
   output logic lsb_first,
   output logic soft_reset,
   output logic [7:0] data_channel_sel,
   output logic data_clock_output_sel,
   output logic frame_clock_output_sel,
   output logic [7:0] chan_wr_addr,
   output logic [7:0] chan_wr_data,
   output logic [7:0] chan_wr_mask,
   output logic chan_wr_stb,
   output logic [1:0] clk_wr_mask
);
   import adccfg_pkg::*;

   if (SPEED_GRADE > 3'h7)
   begin : g_grade_check
      $error("speed grade does not fit its field");
   end

   // -------------------------------------------------
   // serial pin edge detection
   // -------------------------------------------------
   logic sclk_q;
   logic rise;
   logic fall;
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         sclk_q <= 1'b0;
      else
         sclk_q <= sclk;
   end
   assign rise = sclk & ~sclk_q & ~serial_select_n;
   assign fall = ~sclk & sclk_q & ~serial_select_n;

   // -------------------------------------------------
   // frame decoding
   // -------------------------------------------------
   adccfg_state_t state_q;
   logic [4:0] cnt_q;
   logic [15:0] shift_q;
   logic [15:0] shift_d;
   logic rd_q;
   logic [1:0] len_q;
   logic [2:0] left_q;
   logic [7:0] addr_q;
   logic [7:0] tx_q;
   logic byte_done;
   logic instr_done;
   logic [7:0] rx_byte;
   logic [7:0] rd_val;
   logic wr_stb;
   logic lsb_act_q;
   logic [7:0] rx_rev;
   logic [7:0] addr_rev;
   logic [7:0] rd_rev;

   assign shift_d = {shift_q[14:0], sdio_i};
   // bit reversal kept in plain assigns, not inside wider expressions
   assign rx_rev = {<<{shift_d[7:0]}};
   assign addr_rev = {<<{shift_d[15:8]}};
   assign instr_done = rise && state_q == ADCCFG_INSTR
      && cnt_q == 5'(`ADCCFG_INSTR_BITS - 1);
   assign byte_done = rise && state_q == ADCCFG_DATA
      && cnt_q == 5'(`ADCCFG_BYTE_BITS - 1);
   // lsb-first bytes arrive reversed; swap back before use
   assign rx_byte = lsb_act_q ? rx_rev : shift_d[7:0];
   assign wr_stb = byte_done && !rd_q;

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_q <= ADCCFG_IDLE;
         cnt_q <= 5'h0;
         shift_q <= 16'h0000;
         rd_q <= 1'b0;
         len_q <= 2'h0;
         left_q <= 3'h0;
         addr_q <= 8'h00;
      end
      else if (serial_select_n)
      begin
         // a frame cut mid-byte is dropped
         // a stall between bytes keeps the frame; streaming ends here
         state_q <= (state_q == ADCCFG_DATA && cnt_q == 5'h0
            && len_q != 2'h3) ? ADCCFG_DATA : ADCCFG_IDLE;
         cnt_q <= 5'h0;
      end
      else
      begin
         if (state_q == ADCCFG_IDLE)
            state_q <= ADCCFG_INSTR;
         if (rise)
         begin
            shift_q <= shift_d;
            cnt_q <= cnt_q + 5'h1;
            if (instr_done)
            begin
               state_q <= ADCCFG_DATA;
               cnt_q <= 5'h0;
               rd_q <= lsb_act_q ? shift_d[0] : shift_d[15];
               len_q <= lsb_act_q ? {shift_d[1], shift_d[2]}
                  : shift_d[14:13];
               left_q <= lsb_act_q ? {1'b0, shift_d[1], shift_d[2]}
                  : {1'b0, shift_d[14:13]};
               addr_q <= lsb_act_q ? addr_rev : shift_d[7:0];
            end
            else if (byte_done)
            begin
               cnt_q <= 5'h0;
               addr_q <= lsb_act_q ? addr_q + 8'h01 : addr_q - 8'h01;
               if (len_q != 2'h3)
               begin
                  left_q <= left_q - 3'h1;
                  if (left_q == 3'h0)
                     state_q <= ADCCFG_IDLE;
               end
            end
         end
      end
   end

   // -------------------------------------------------
   // shadow and active registers
   // -------------------------------------------------
   adccfg_byte_t port_cfg_q;
   adccfg_byte_t sel_up_sh_q;
   adccfg_byte_t sel_lo_sh_q;
   adccfg_byte_t sel_up_q;
   adccfg_byte_t sel_lo_q;
   logic lsb_sh_q;
   logic srst_sh_q;
   logic xfer;
   logic lsb_wr;
   logic srst_wr;

   assign lsb_wr = rx_byte[`ADCCFG_BIT_LSB_HI]
      | rx_byte[`ADCCFG_BIT_LSB_LO];
   assign srst_wr = rx_byte[`ADCCFG_BIT_SRST_HI]
      | rx_byte[`ADCCFG_BIT_SRST_LO];
   assign xfer = wr_stb && addr_q == `ADCCFG_OFS_TRANSFER
      && rx_byte == `ADCCFG_XFER_GO;

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         lsb_sh_q <= 1'b0;
         srst_sh_q <= 1'b0;
         sel_up_sh_q <= `ADCCFG_RST_SEL_UPPER;
         sel_lo_sh_q <= `ADCCFG_RST_SEL_LOWER;
      end
      else if (soft_reset)
      begin
         lsb_sh_q <= 1'b0;
         srst_sh_q <= 1'b0;
         sel_up_sh_q <= `ADCCFG_RST_SEL_UPPER;
         sel_lo_sh_q <= `ADCCFG_RST_SEL_LOWER;
      end
      else if (wr_stb)
      begin
         unique case (addr_q)
            `ADCCFG_OFS_PORT_CFG:
            begin
               lsb_sh_q <= lsb_wr;
               srst_sh_q <= srst_wr;
            end
            `ADCCFG_OFS_SEL_UPPER: sel_up_sh_q <= {4'h0, rx_byte[3:0]};
            `ADCCFG_OFS_SEL_LOWER: sel_lo_sh_q <= {2'h0, rx_byte[5:0]};
            default: ; // part id and grade ignore writes
         endcase
      end
   end

   // port config bits act at once so the host can resync shift order
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         lsb_act_q <= 1'b0;
         soft_reset <= 1'b0;
      end
      else if (soft_reset)
      begin
         lsb_act_q <= 1'b0;
         soft_reset <= 1'b0; // self clearing after one cycle
      end
      else if (wr_stb && addr_q == `ADCCFG_OFS_PORT_CFG
         && (state_q == ADCCFG_DATA))
      begin
         lsb_act_q <= lsb_wr;
         soft_reset <= srst_wr;
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sel_up_q <= `ADCCFG_RST_SEL_UPPER;
         sel_lo_q <= `ADCCFG_RST_SEL_LOWER;
      end
      else if (soft_reset)
      begin
         sel_up_q <= `ADCCFG_RST_SEL_UPPER;
         sel_lo_q <= `ADCCFG_RST_SEL_LOWER;
      end
      else if (xfer)
      begin
         sel_up_q <= sel_up_sh_q;
         sel_lo_q <= sel_lo_sh_q;
      end
   end

   // mirrored image: 0 lsb srst 1 1 srst lsb 0
   assign port_cfg_q = {1'b0, lsb_sh_q, srst_sh_q, 2'b11,
      srst_sh_q, lsb_sh_q, 1'b0};
   assign lsb_first = lsb_act_q;
   assign data_channel_sel = {sel_up_q[3:0], sel_lo_q[3:0]};
   assign data_clock_output_sel = sel_lo_q[5];
   assign frame_clock_output_sel = sel_lo_q[4];

   // -------------------------------------------------
   // channel-specific write broadcast
   // -------------------------------------------------
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         chan_wr_stb <= 1'b0;
         chan_wr_addr <= 8'h00;
         chan_wr_data <= 8'h00;
         chan_wr_mask <= 8'h00;
         clk_wr_mask <= 2'h0;
      end
      else
      begin
         chan_wr_stb <= wr_stb && addr_q != `ADCCFG_OFS_TRANSFER
            && addr_q > `ADCCFG_OFS_SEL_LOWER;
         if (wr_stb)
         begin
            chan_wr_addr <= addr_q;
            chan_wr_data <= rx_byte;
            chan_wr_mask <= data_channel_sel;
            clk_wr_mask <= {data_clock_output_sel,
               frame_clock_output_sel};
         end
      end
   end

   // -------------------------------------------------
   // readback
   // -------------------------------------------------
   always_comb
   begin
      unique case (addr_q)
         `ADCCFG_OFS_PORT_CFG: rd_val = port_cfg_q;
         `ADCCFG_OFS_PART_ID: rd_val = PART_ID;
         `ADCCFG_OFS_GRADE: rd_val = {1'b0, SPEED_GRADE, 4'h0};
         `ADCCFG_OFS_SEL_UPPER: rd_val = sel_up_sh_q;
         `ADCCFG_OFS_SEL_LOWER: rd_val = sel_lo_sh_q;
         default: rd_val = 8'h00;
      endcase
   end

   assign rd_rev = {<<{rd_val}};

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         tx_q <= 8'h00;
         sdio_oe_n <= 1'b1;
         sdio_o <= 1'b0;
      end
      else if (serial_select_n || state_q != ADCCFG_DATA || !rd_q)
      begin
         sdio_oe_n <= 1'b1;
         sdio_o <= 1'b0;
         if (state_q == ADCCFG_DATA && rd_q && cnt_q == 5'h0)
            tx_q <= lsb_act_q ? rd_rev : rd_val;
      end
      else if (fall)
      begin
         // drive after falling edge so host samples on rising
         sdio_oe_n <= 1'b0;
         sdio_o <= (cnt_q == 5'h0) ?
            (lsb_act_q ? rd_val[0] : rd_val[7]) : tx_q[7];
         if (cnt_q == 5'h0)
            tx_q <= (lsb_act_q ? rd_rev : rd_val) << 1;
         else
            tx_q <= tx_q << 1;
      end
   end
endmodule // adccfg_regs

// [adccfg_regs_monitor.sv]
// checker on the ports of the configuration register bank
// assumes one clock domain and an async active-low reset
`timescale 1ns/1ps
module adccfg_regs_monitor(
   input logic clk,
   input logic rst_n,
   input logic serial_select_n,
   input logic sdio_oe_n,
   input logic lsb_first,
   input logic soft_reset,
   input logic [7:0] data_channel_sel,
   input logic data_clock_output_sel,
   input logic frame_clock_output_sel,
   input logic [7:0] chan_wr_addr,
   input logic [7:0] chan_wr_mask,
   input logic chan_wr_stb,
   input logic [1:0] clk_wr_mask
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   // ------------------------------------------
   // sequences and properties
   // ------------------------------------------
   sequence s_defaults;
      data_channel_sel == 8'hFF && !lsb_first && !data_clock_output_sel
         && !frame_clock_output_sel;
   endsequence
   // settings may only move inside a frame or on a soft reset
   sequence s_in_frame;
      !$past(serial_select_n) || soft_reset || $past(soft_reset);
   endsequence
   a_srst_pulse: assert property (soft_reset |=> !soft_reset)
      else $error("soft reset pulse too long");
   a_srst_defaults: assert property (soft_reset |-> ##[0:2] s_defaults)
      else $error("soft reset did not restore defaults");
   a_stb_range: assert property (chan_wr_stb |->
      chan_wr_addr >= 8'h06 && chan_wr_addr <= 8'hFE)
      else $error("channel strobe for a bank address");
   a_stb_pulse: assert property (chan_wr_stb |=> !chan_wr_stb)
      else $error("channel strobe too long");
   a_mask_match: assert property (chan_wr_stb |-> chan_wr_mask ==
      data_channel_sel && clk_wr_mask == {data_clock_output_sel,
      frame_clock_output_sel})
      else $error("write mask differs from active selects");
   a_sel_frame: assert property ($changed(data_channel_sel) |->
      s_in_frame)
      else $error("channel select moved outside a frame");
   a_lsb_frame: assert property ($changed(lsb_first) |-> s_in_frame)
      else $error("bit order moved outside a frame");
   a_oe_frame: assert property (!sdio_oe_n |-> !$past(serial_select_n))
      else $error("data pin driven outside a frame");
endmodule // adccfg_regs_monitor
bind adccfg_regs adccfg_regs_monitor u_mon(.clk, .rst_n, .serial_select_n,
   .sdio_oe_n, .lsb_first, .soft_reset, .data_channel_sel,
   .data_clock_output_sel, .frame_clock_output_sel, .chan_wr_addr,
   .chan_wr_mask, .chan_wr_stb, .clk_wr_mask);

// [adccfg_host.sv]
// serial port host model, one to four byte frames, either bit order
// assumes clk is the device clock; sclk idles low between frames
`timescale 1ns/1ps
module adccfg_host(
   input wire logic clk,
   input wire logic sdio,
   output logic sclk,
   output logic serial_select_n,
   output logic sdio_h,
   output logic host_oe
);
   logic lsb = 1'b0;
   logic [1:0] wlen = 2'b00;
   initial {sclk, serial_select_n, sdio_h, host_oe} = 4'b0101;
   // ------------------------------------------
   // one frame: instruction then wlen+1 bytes
   // ------------------------------------------
   // any address, reserved bits zero
   // every byte of a longer frame carries the same data
   task automatic xfer(input logic rd, input logic [7:0] a,
      input logic [7:0] wd, output logic [7:0] q);
      logic [15:0] f;
      int n;
      int b;
      f = {rd, wlen, 5'h00, a};
      n = 16 + 8 * (wlen + 1);
      q = 8'h00;
      @(posedge clk);
      #1 serial_select_n = 1'b0;
      for (int i = 0; i < n; i++)
      begin
         b = (i - 16) % 8;
         sclk = 1'b0;
         host_oe = !(rd && i > 15);
         if (i < 16)
            sdio_h = lsb ? f[i] : f[15-i];
         else
            sdio_h = lsb ? wd[b] : wd[7-b];
         repeat (3) @(posedge clk);
         #1 if (i > 15) q[lsb ? b : 7-b] = sdio;
         sclk = 1'b1;
         repeat (3) @(posedge clk);
         #1;
      end
      sclk = 1'b0;
      repeat (3) @(posedge clk);
      #1 serial_select_n = 1'b1;
      host_oe = 1'b1;
      repeat (3) @(posedge clk);
      #1;
   endtask
endmodule // adccfg_host

// [test_adc_chip_config_registers.sv]
// self-checking bench for the configuration register bank
// assumes the host model and the bound checker
`timescale 1ns/1ps
module test_adc_chip_config_registers;
   logic clk, rst_n, sclk, ssn, sdio_h, host_oe, sdio_o, sdio_oe_n, lsb_first;
   logic soft_reset, data_clock_output, frame_clock_output, chan_wr_stb;
   logic [7:0] sel, wa, wd, wm, q, n_stb, n_srst;
   logic [1:0] cm;
   int n_mismatch, n_tests;
   // released line shows the inverse of its last value
   wire sdio = !sdio_oe_n ? sdio_o : host_oe ? sdio_h : ~sdio_h;
   adccfg_regs #(.PART_ID(8'hA7), .SPEED_GRADE(3'h5)) dut(.clk, .rst_n,
      .sclk, .serial_select_n(ssn), .sdio_i(sdio), .sdio_o, .sdio_oe_n,
      .lsb_first, .soft_reset, .data_channel_sel(sel),
      .data_clock_output_sel(data_clock_output), .frame_clock_output_sel(frame_clock_output),
      .chan_wr_addr(wa), .chan_wr_data(wd), .chan_wr_mask(wm), .chan_wr_stb,
      .clk_wr_mask(cm));
   adccfg_host h(.clk, .sdio, .sclk, .serial_select_n(ssn), .sdio_h,
      .host_oe);
   initial
   begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   always @(posedge clk) if (chan_wr_stb === 1'b1) n_stb <= n_stb + 8'h01;
   always @(posedge clk) if (soft_reset === 1'b1) n_srst <= n_srst + 8'h01;
   // ------------------------------------------
   // access and checking tasks
   // ------------------------------------------
   task automatic conclude;
      $display("checks %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [7:0] s, input logic [7:0] e);
      n_tests++;
      if (s !== e)
      begin
         n_mismatch++;
         $display("Error %0t: got %h want %h", $time, s, e);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] r;
      h.xfer(1'b0, a, d, r);
   endtask
   task automatic rd(input logic [7:0] a);
      h.xfer(1'b1, a, 8'h00, q);
   endtask
   initial
   begin
      repeat (20000) @(posedge clk);
      n_mismatch++;
      conclude;
   end
   initial
   begin
      n_mismatch = 0;
      n_tests = 0;
      n_stb = 8'h00;
      n_srst = 8'h00;
      rst_n = 1'b0;
      repeat (3) @(posedge clk);
      #1 rst_n = 1'b1;
      chk(sel, 8'hFF);
      chk({5'h0, lsb_first, data_clock_output, frame_clock_output}, 8'h00);
      rd(8'h00);
      chk(q, 8'h18);
      rd(8'h01);
      chk(q, 8'hA7);
      rd(8'h02);
      chk(q, 8'h50);
      rd(8'h04);
      chk(q, 8'h0F);
      rd(8'h05);
      chk(q, 8'h0F);
      wr(8'h01, 8'h00);
      rd(8'h01);
      chk(q, 8'hA7);
      wr(8'h02, 8'h00);
      rd(8'h02);
      chk(q, 8'h50);
      $display("test defaults done");
      wr(8'h05, 8'h32);
      wr(8'h04, 8'h09);
      chk(sel, 8'hFF);
      wr(8'hFF, 8'h01);
      chk(sel, 8'h92);
      chk({6'h0, data_clock_output, frame_clock_output}, 8'h03);
      wr(8'h08, 8'h04);
      chk(n_stb, 8'h01);
      chk(wa, 8'h08);
      chk(wd, 8'h04);
      chk(wm, 8'h92);
      chk({6'h0, cm}, 8'h03);
      $display("test channel select done");
      wr(8'h00, 8'h58);
      chk({7'h0, lsb_first}, 8'h01);
      h.lsb = 1'b1;
      rd(8'h05);
      chk(q, 8'h32);
      // two-byte write, lsb-first address counts up
      h.wlen = 2'b01;
      wr(8'h04, 8'h09);
      h.wlen = 2'b00;
      rd(8'h05);
      chk(q, 8'h09);
      rd(8'h04);
      chk(q, 8'h09);
      wr(8'hFF, 8'h01);
      chk(sel, 8'h99);
      chk({6'h0, data_clock_output, frame_clock_output}, 8'h00);
      wr(8'h00, 8'h38);
      h.lsb = 1'b0;
      chk(n_srst, 8'h01);
      chk(sel, 8'hFF);
      chk({5'h0, lsb_first, data_clock_output, frame_clock_output}, 8'h00);
      rd(8'h05);
      chk(q, 8'h0F);
      rd(8'h00);
      chk(q, 8'h18);
      $display("test port config done");
      // two-byte write, msb-first address counts down
      h.wlen = 2'b01;
      wr(8'h05, 8'h06);
      h.wlen = 2'b00;
      rd(8'h04);
      chk(q, 8'h06);
      rd(8'h05);
      chk(q, 8'h06);
      wr(8'hFF, 8'h01);
      chk(sel, 8'h66);
      // reset again in mid-run with settings away from defaults
      rst_n = 1'b0;
      repeat (2) @(posedge clk);
      #1 rst_n = 1'b1;
      chk(sel, 8'hFF);
      rd(8'h04);
      chk(q, 8'h0F);
      $display("test multi-byte and reset done");
      conclude;
   end
endmodule // test_adc_chip_config_registers
